// file: asrc_pkg.sv
// Package with timing constants and state codes for the static memory host.
package asrc_pkg;
	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 20;
	localparam int DATA_W = 4;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_READ_ACCESS_NS = 12;
	localparam int T_OE_VALID_NS = 6;
	localparam int T_WRITE_PULSE_NS = 8;
	localparam int T_DATA_SETUP_NS = 6;
	localparam int T_FLOAT_NS = 6;
	localparam int T_WRITE_LOWZ_NS = 3;
	// Least times round up, never below one cycle.
	function automatic int nsToCycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int READ_CYC = nsToCycles(T_READ_ACCESS_NS);
	localparam int WRITE_CYC = nsToCycles(T_WRITE_PULSE_NS);
	localparam int SETUP_CYC = nsToCycles(T_DATA_SETUP_NS);
	localparam int FLOAT_CYC = nsToCycles(T_FLOAT_NS);
	localparam int TURN_CYC = nsToCycles(T_WRITE_LOWZ_NS);
	localparam int CNT_W = 4;
	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_READ = 5'h02,
		ST_WRITE = 5'h04,
		ST_FLOAT = 5'h08,
		ST_TURN = 5'h10
	} asrc_state_e;
endpackage

// file: asrc_host.sv
// Synchronous host that drives an asynchronous 1M x 4 static memory.
// Function
// - Write is overlap of select and write enable low, at least 8 ns.
// - Address valid 8 ns before end of write.
// - Select low 8 ns before end of write.
// - Address stable by the write start, margin 0 ns.
// - Address held until write ends, recovery 0 ns.
// - Write data valid 6 ns before write end, held 0 ns after.
// - Write enable or select high while address changes.
// - Address valid before or with select falling.
// - Host never drives data while memory outputs are enabled.
module asrc_host (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [asrc_pkg::ADDR_W-1:0] reqAddr,
	input wire logic [asrc_pkg::DATA_W-1:0] reqData,
	output logic reqReady,
	output logic rspValid,
	output logic [asrc_pkg::DATA_W-1:0] rspData,
	output logic [asrc_pkg::ADDR_W-1:0] wordAddress,
	output logic chipSelN,
	output logic outEnN,
	output logic writeEnN,
	input wire logic [asrc_pkg::DATA_W-1:0] dataLinesIn,
	output logic [asrc_pkg::DATA_W-1:0] dataLinesOut,
	output logic dataLinesOe
);
	import asrc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		asrc_state_e st;
		logic [CNT_W-1:0] cnt;
		logic ready;
		logic rspV;
		logic [DATA_W-1:0] rsp;
		logic [ADDR_W-1:0] addr;
		logic csN;
		logic oeN;
		logic weN;
		logic [DATA_W-1:0] dout;
		logic doe;
	} asrc_regs_s;

	asrc_regs_s r_q, r_d;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.rspV = 1'b0;
		case (r_q.st)
			ST_IDLE: begin
				if (reqValid && r_q.ready) begin
					// Address is set at the same clock edge at which select falls.
					r_d.addr = reqAddr;
					r_d.csN = 1'b0;
					r_d.ready = 1'b0;
					if (reqWrite) begin
						// Select and write enable fall together.
						r_d.weN = 1'b0;
						r_d.oeN = 1'b1;
						r_d.dout = reqData;
						r_d.doe = 1'b1;
						r_d.cnt = CNT_W'(WRITE_CYC - 1);
						r_d.st = ST_WRITE;
					end else begin
						r_d.oeN = 1'b0;
						r_d.cnt = CNT_W'(READ_CYC - 1);
						r_d.st = ST_READ;
					end
				end
			end
			ST_READ: begin
				if (r_q.cnt != '0) begin
					r_d.cnt = r_q.cnt - 1'b1;
				end else begin
					// Sampled after full access time, before the strobes rise.
					r_d.rsp = dataLinesIn;
					r_d.rspV = 1'b1;
					r_d.csN = 1'b1;
					r_d.oeN = 1'b1;
					r_d.cnt = CNT_W'(FLOAT_CYC - 1);
					r_d.st = ST_FLOAT;
				end
			end
			ST_WRITE: begin
				if (r_q.cnt != '0) begin
					r_d.cnt = r_q.cnt - 1'b1;
				end else begin
					// Address and data stay put across the ending edge.
					r_d.weN = 1'b1;
					r_d.csN = 1'b1;
					r_d.cnt = CNT_W'(TURN_CYC - 1);
					r_d.st = ST_TURN;
				end
			end
			ST_TURN: begin
				// Data drive ends one cycle after the write ends.
				r_d.doe = 1'b0;
				if (r_q.cnt != '0) begin
					r_d.cnt = r_q.cnt - 1'b1;
				end else begin
					r_d.ready = 1'b1;
					r_d.st = ST_IDLE;
				end
			end
			ST_FLOAT: begin
				// Memory outputs float before the next access may start.
				if (r_q.cnt != '0) begin
					r_d.cnt = r_q.cnt - 1'b1;
				end else begin
					r_d.ready = 1'b1;
					r_d.st = ST_IDLE;
				end
			end
			default: begin
				r_d.st = ST_IDLE;
				r_d.csN = 1'b1;
				r_d.oeN = 1'b1;
				r_d.weN = 1'b1;
				r_d.doe = 1'b0;
				r_d.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			r_q <= '{st: ST_IDLE, cnt: '0, ready: 1'b1, rspV: 1'b0,
				rsp: '0, addr: '0, csN: 1'b1, oeN: 1'b1, weN: 1'b1,
				dout: '0, doe: 1'b0};
		end else begin
			r_q <= r_d;
		end
	end

	assign reqReady = r_q.ready;
	assign rspValid = r_q.rspV;
	assign rspData = r_q.rsp;
	assign wordAddress = r_q.addr;
	assign chipSelN = r_q.csN;
	assign outEnN = r_q.oeN;
	assign writeEnN = r_q.weN;
	assign dataLinesOut = r_q.dout;
	assign dataLinesOe = r_q.doe;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence seqWriteStart;
		$fell(writeEnN) && !chipSelN;
	endsequence

	sequence seqReadStart;
		$fell(outEnN) && !chipSelN;
	endsequence

	AST_NO_CONTENTION: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!(dataLinesOe && !outEnN))
		else $error("Host drives data while memory outputs enabled.");
	AST_ADDR_STABLE_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$changed(wordAddress) |-> $past(chipSelN) && $past(writeEnN))
		else $error("Address changed during write.");
	AST_WRITE_WIDTH: assert property (@(posedge clk_sys) disable iff (sys_rst)
		seqWriteStart |=> writeEnN && chipSelN)
		else $error("Write pulse has wrong width.");
	AST_DATA_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(writeEnN) |-> dataLinesOe && $stable(dataLinesOut))
		else $error("Write data not held at end of write.");
	AST_ADDR_BEFORE_CS: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$fell(chipSelN) |-> wordAddress == $past(reqAddr))
		else $error("Address not set with select.");
	AST_SYNC_FALL: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$fell(writeEnN) |-> $fell(chipSelN) && outEnN)
		else $error("Write enable fell before select.");
	AST_READ_RSP: assert property (@(posedge clk_sys) disable iff (sys_rst)
		seqReadStart |=> rspValid && chipSelN && outEnN)
		else $error("Read answer not on time.");
	AST_FLOAT_GAP: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(outEnN) |-> !reqReady ##1 reqReady)
		else $error("No float gap after read.");
	AST_TURN_DROP: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(writeEnN) |=> !dataLinesOe)
		else $error("Data drive not released after write.");

	// ----------------------------------------------------------------
	// Pin protocol checks
	// ----------------------------------------------------------------
	AST_WRITE_DATA: assert property (@(posedge clk_sys) disable iff (sys_rst)
		seqWriteStart |-> dataLinesOe && dataLinesOut == $past(reqData))
		else $error("Write data not driven at write start.");
	AST_ONE_STROBE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!chipSelN |-> outEnN != writeEnN)
		else $error("Selected access has no single strobe.");
	AST_IDLE_PINS: assert property (@(posedge clk_sys) disable iff (sys_rst)
		reqReady |-> chipSelN && outEnN && writeEnN && !dataLinesOe)
		else $error("Pins not at rest while ready.");
	AST_RSP_PULSE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rspValid |=> !rspValid)
		else $error("Read answer longer than one cycle.");
	AST_READ_ADDR_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
		seqReadStart |=> $stable(wordAddress))
		else $error("Address moved during read.");
	AST_TURN_GAP: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(writeEnN) |-> !reqReady ##1 reqReady)
		else $error("No turn gap after write.");
endmodule

// file: asrc_sram_model.sv
// Behavioural model of the asynchronous 1M x 4 static memory.
module asrc_sram_model (
	input wire logic [asrc_pkg::ADDR_W-1:0] wordAddress,
	input wire logic chipSelN,
	input wire logic outEnN,
	input wire logic writeEnN,
	input wire logic [asrc_pkg::DATA_W-1:0] busIn,
	output logic [asrc_pkg::DATA_W-1:0] memOut,
	output logic memOe
);
	timeunit 1ns;
	timeprecision 1ps;
	import asrc_pkg::*;
	logic [DATA_W-1:0] cells [logic [ADDR_W-1:0]];
	logic rd;
	logic wrEndN;
	logic wrOpen = 1'b0;
	assign rd = !chipSelN && !outEnN && writeEnN;
	assign wrEndN = chipSelN | writeEnN;
	initial {memOe, memOut} = '0;
	// Turn-on waits 3 ns, turn-off lands at 2 ns.
	always @(rd)
		memOe <= #(rd ? 3 : 2) rd;
	always @(wordAddress, rd)
		if (rd)
			memOut <= #5 cells.exists(wordAddress) ? cells[wordAddress] : 4'h0;
	// A write needs a falling strobe first, so reset stores nothing.
	always @(negedge wrEndN)
		wrOpen = 1'b1;
	always @(posedge wrEndN)
		if (wrOpen && !$isunknown(wordAddress)) begin
			cells[wordAddress] = busIn;
			wrOpen = 1'b0;
		end
endmodule

// file: asrc_host_tb.sv
// Self-checking bench for the static memory host.
module asrc_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import asrc_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic reqValid = 1'b0;
	logic reqWrite = 1'b0;
	logic [ADDR_W-1:0] reqAddr = '0;
	logic [DATA_W-1:0] reqData = '0;
	logic reqReady, rspValid, chipSelN, outEnN, writeEnN, dataLinesOe, memOe;
	logic [DATA_W-1:0] rspData, dataLinesOut, memOut, busWire;
	logic [ADDR_W-1:0] wordAddress;
	logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
	int failCount = 0;
	int samplesChecked = 0;
	int cycles = 0;
	localparam logic [ADDR_W-1:0] ADR [4] = '{20'h00000, 20'hFFFFF,
		20'h5A5A5, 20'hA5A5A};
	localparam logic [DATA_W-1:0] DAT [4] = '{4'hA, 4'h5, 4'hF, 4'h0};
	always #50 clk_sys = ~clk_sys;
	// Released bus shows the inverse of the last value read.
	assign busWire = dataLinesOe ? dataLinesOut : (memOe ? memOut : ~memOut);
	asrc_host DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .reqValid(reqValid),
		.reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
		.reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
		.wordAddress(wordAddress), .chipSelN(chipSelN), .outEnN(outEnN),
		.writeEnN(writeEnN), .dataLinesIn(busWire),
		.dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe));
	asrc_sram_model MEM (.wordAddress(wordAddress), .chipSelN(chipSelN),
		.outEnN(outEnN), .writeEnN(writeEnN), .busIn(busWire),
		.memOut(memOut), .memOe(memOe));
	task automatic stopTest();
		$display("fails=%0d checks=%0d", failCount, samplesChecked);
		if (failCount == 0 && samplesChecked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic checkVal(input logic [ADDR_W-1:0] got, exp);
		samplesChecked++;
		if (got !== exp) begin
			failCount++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 400) begin
			failCount++;
			stopTest();
		end
	end
	always @(negedge clk_sys)
		if (!sys_rst)
			checkVal(20'(dataLinesOe & memOe), 20'h0);
	// One transfer; a second request is offered while busy and must be lost.
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int n;
		logic [3:0] pins;
		n = 0;
		@(posedge clk_sys);
		reqValid <= 1'b1;
		reqWrite <= w;
		reqAddr <= a;
		reqData <= d;
		#1;
		while (reqReady !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		// The request is taken at this edge; strobes fall just after it.
		@(posedge clk_sys);
		reqValid <= 1'b0;
		#1;
		pins = {chipSelN, outEnN, writeEnN, dataLinesOe};
		checkVal(20'(pins), w ? 20'h5 : 20'h2);
		checkVal(wordAddress, a);
		if (w)
			checkVal(20'(dataLinesOut), 20'(d));
		// Offered while busy, sampled with ready low, so it must be lost.
		@(posedge clk_sys);
		reqValid <= 1'b1;
		reqData <= ~d;
		#1;
		pins = {chipSelN, outEnN, writeEnN, dataLinesOe};
		checkVal(20'(pins), w ? 20'hF : 20'hE);
		checkVal(wordAddress, a);
		if (w) begin
			checkVal(20'(dataLinesOut), 20'(d));
			shadow[a] = d;
		end else begin
			checkVal(20'(rspValid), 20'h1);
			checkVal(20'(rspData), 20'(shadow[a]));
		end
		@(posedge clk_sys);
		reqValid <= 1'b0;
		#1;
		checkVal(20'({reqReady, dataLinesOe, rspValid}), 20'h4);
	endtask
	task automatic scnWriteAll();
		for (int i = 0; i < 4; i++)
			xfer(1'b1, ADR[i], DAT[i]);
	endtask
	task automatic scnReadBack();
		for (int i = 3; i >= 0; i--)
			xfer(1'b0, ADR[i], 4'h0);
	endtask
	task automatic scnOverwrite();
		xfer(1'b1, ADR[1], 4'h9);
		xfer(1'b0, ADR[1], 4'h0);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		#1;
		checkVal(20'({reqReady, chipSelN, outEnN, writeEnN, dataLinesOe,
			rspValid}), 20'h3C);
		scnWriteAll();
		scnReadBack();
		scnOverwrite();
		stopTest();
	end
endmodule
